// ==== ast_pkg.sv ====
// constants and types for the asynchronous serial transmitter
package ast_pkg;

	localparam logic [2:0] ADDR_TX_STATUS_CONTROL = 3'h0;
	localparam logic [2:0] ADDR_RX_STATUS_CONTROL = 3'h1;
	localparam logic [2:0] ADDR_BAUD_CONTROL      = 3'h2;
	localparam logic [2:0] ADDR_DIVISOR_LOW       = 3'h3;
	localparam logic [2:0] ADDR_DIVISOR_HIGH      = 3'h4;
	localparam logic [2:0] ADDR_HOLDING_BUFFER    = 3'h5;
	localparam logic [2:0] ADDR_INTERRUPT_CONTROL = 3'h6;

	// transmit_status_control fields
	localparam int TXS_NINTH_DATA   = 0;
	localparam int TXS_SHIFT_EMPTY  = 1;
	localparam int TXS_HIGH_SPEED   = 2;
	localparam int TXS_SYNC_MODE    = 4;
	localparam int TXS_TX_ENABLE    = 5;
	localparam int TXS_NINE_BIT     = 6;
	// receive_status_control field
	localparam int RXS_PORT_ENABLE  = 7;
	// baud_control field
	localparam int BDC_WIDE_DIVISOR = 3;
	// interrupt_control fields
	localparam int INT_TX_ENABLE    = 0;
	localparam int INT_PERIPH       = 1;
	localparam int INT_GLOBAL       = 2;
	localparam int INT_BUF_EMPTY    = 4;

	localparam logic [7:0]  RESET_BYTE         = 8'h00;
	localparam logic [15:0] RESET_DIVISOR      = 16'h0000;
	localparam logic [3:0]  DATA_BITS_EIGHT    = 4'h8;
	localparam logic [3:0]  DATA_BITS_NINE     = 4'h9;
	localparam logic [1:0]  FLAG_VALID_DELAY   = 2'h2;
	localparam logic [3:0]  PRESCALE_HIGH      = 4'h0;
	localparam logic [3:0]  PRESCALE_MID       = 4'h3;
	localparam logic [3:0]  PRESCALE_LOW       = 4'hF;

	typedef enum logic [1:0] {
		AST_IDLE,
		AST_START,
		AST_DATA,
		AST_STOP
	} ast_state_e;

endpackage : ast_pkg

// ==== ast_baud_gen.sv ====
// baud tick generator with 8 or 16-bit divisor
`timescale 1ns/1ns
module ast_baud_gen
	import ast_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// configuration
	input  wire logic        run,
	input  wire logic [15:0] divisor,
	input  wire logic        wide_divisor_select,
	input  wire logic        high_speed_rate_select,
	// tick out
	output logic             bit_tick
);

	typedef struct packed {
		logic [15:0] count;
		logic [3:0]  pre;
	} ast_bg_s;

	ast_bg_s st_reg;
	ast_bg_s st_next;
	logic [15:0] limit;
	logic [3:0]  pre_limit;

	always_comb begin
		limit     = wide_divisor_select ? divisor : {8'h00, divisor[7:0]};
		// prescale 16, 4 or 1 clocks per divisor step, by rate selects
		if (wide_divisor_select && high_speed_rate_select) begin
			pre_limit = PRESCALE_HIGH;
		end else if (wide_divisor_select || high_speed_rate_select) begin
			pre_limit = PRESCALE_MID;
		end else begin
			pre_limit = PRESCALE_LOW;
		end
		st_next = st_reg;
		if (!run) begin
			st_next.count = 16'h0000;
			st_next.pre   = 4'h0;
		end else if (st_reg.pre != pre_limit) begin
			st_next.pre = st_reg.pre + 4'h1;
		end else begin
			st_next.pre = 4'h0;
			if (st_reg.count >= limit) begin
				st_next.count = 16'h0000;
			end else begin
				st_next.count = st_reg.count + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// tick is combinational: a registered tick would stretch the start bit by a clock
	assign bit_tick = run && (st_reg.pre == pre_limit) && (st_reg.count >= limit);

endmodule : ast_baud_gen

// ==== ast_transmitter.sv ====
// asynchronous serial transmitter with registers and pin control
`timescale 1ns/1ns
module ast_transmitter
	import ast_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// register port
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// general purpose fallback for the transmit pin
	input  wire logic       gpio_out,
	input  wire logic       gpio_oe,
	// transmit_clock_pin
	output logic            transmit_clock_pin_o,
	output logic            transmit_clock_pin_oe,
	// interrupt request towards the core
	output logic            transmit_irq
);

	typedef struct packed {
		logic [7:0]  tx_ctl;
		logic        port_enable;
		logic        wide_div;
		logic [15:0] divisor;
		logic [7:0]  hold_data;
		logic        hold_ninth;
		logic        hold_full;
		logic [8:0]  shifter;
		logic [3:0]  bits_left;
		logic [3:0]  frame_bits;
		ast_state_e  state;
		logic        line;
		logic [1:0]  flag_delay;
		logic        flag_shown;
		logic [2:0]  int_ctl;
		logic [7:0]  rdata;
	} ast_tx_s;

	ast_tx_s st_reg;
	ast_tx_s st_next;
	logic    tx_active;
	logic    bit_tick;
	logic    busy;
	logic    buf_empty_true;
	logic    write_hold;

	function automatic logic [7:0] sel_byte(input logic [2:0] a, input ast_tx_s s,
		input logic shift_empty, input logic buf_empty);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			ADDR_TX_STATUS_CONTROL: begin
				v = s.tx_ctl;
				v[TXS_SHIFT_EMPTY] = shift_empty;
			end
			ADDR_RX_STATUS_CONTROL: v[RXS_PORT_ENABLE] = s.port_enable;
			ADDR_BAUD_CONTROL:      v[BDC_WIDE_DIVISOR] = s.wide_div;
			ADDR_DIVISOR_LOW:       v = s.divisor[7:0];
			ADDR_DIVISOR_HIGH:      v = s.divisor[15:8];
			ADDR_HOLDING_BUFFER:    v = s.hold_data;
			ADDR_INTERRUPT_CONTROL: begin
				v[2:0] = s.int_ctl;
				v[INT_BUF_EMPTY] = buf_empty;
			end
			default:                v = 8'h00;
		endcase
		return v;
	endfunction : sel_byte

	// only the transmit section lives here; receive side shares format and rate
	assign tx_active = st_reg.tx_ctl[TXS_TX_ENABLE] && !st_reg.tx_ctl[TXS_SYNC_MODE]
		&& st_reg.port_enable;
	assign busy = (st_reg.state != AST_IDLE);
	assign write_hold = reg_wr && (reg_addr == ADDR_HOLDING_BUFFER);

	ast_baud_gen u_baud (
		.clk                    (clk),
		.srst                   (srst),
		.run                    (busy),
		.divisor                (st_reg.divisor),
		.wide_divisor_select    (st_reg.wide_div),
		.high_speed_rate_select (st_reg.tx_ctl[TXS_HIGH_SPEED]),
		.bit_tick               (bit_tick)
	);

	assign buf_empty_true = st_reg.tx_ctl[TXS_TX_ENABLE] && !st_reg.hold_full;

	always_comb begin
		st_next = st_reg;
		st_next.rdata = 8'h00;
		if (reg_rd) begin
			st_next.rdata = sel_byte(reg_addr, st_reg, !busy, st_reg.flag_shown);
		end
		if (reg_wr) begin
			case (reg_addr)
				ADDR_TX_STATUS_CONTROL: begin
					st_next.tx_ctl = reg_wdata;
					st_next.tx_ctl[TXS_SHIFT_EMPTY] = 1'b0;
				end
				ADDR_RX_STATUS_CONTROL: st_next.port_enable = reg_wdata[RXS_PORT_ENABLE];
				ADDR_BAUD_CONTROL:      st_next.wide_div = reg_wdata[BDC_WIDE_DIVISOR];
				ADDR_DIVISOR_LOW:       st_next.divisor[7:0] = reg_wdata;
				ADDR_DIVISOR_HIGH:      st_next.divisor[15:8] = reg_wdata;
				ADDR_INTERRUPT_CONTROL: st_next.int_ctl = reg_wdata[2:0];
				default: begin
				end
			endcase
		end
		if (write_hold) begin
			st_next.hold_data  = reg_wdata;
			st_next.hold_ninth = st_reg.tx_ctl[TXS_NINTH_DATA];
			st_next.hold_full  = 1'b1;
		end

		// empty flag seen by software lags a buffer write by two cycles
		if (write_hold) begin
			st_next.flag_delay = FLAG_VALID_DELAY;
		end else if (st_reg.flag_delay != 2'h0) begin
			st_next.flag_delay = st_reg.flag_delay - 2'h1;
		end
		if (write_hold || st_reg.flag_delay > 2'h1) begin
			st_next.flag_shown = st_reg.flag_shown;
		end else begin
			st_next.flag_shown = buf_empty_true;
		end

		case (st_reg.state)
			AST_IDLE: begin
				st_next.line = 1'b1;
				// load on the clock after the buffer becomes full when idle
				if (tx_active && st_reg.hold_full) begin
					st_next.shifter    = {st_reg.hold_ninth, st_reg.hold_data};
					st_next.frame_bits = st_reg.tx_ctl[TXS_NINE_BIT] ? DATA_BITS_NINE
						: DATA_BITS_EIGHT;
					st_next.hold_full  = write_hold;
					st_next.line       = 1'b0;
					st_next.state      = AST_START;
				end
			end
			AST_START: begin
				if (bit_tick) begin
					st_next.line      = st_reg.shifter[0];
					st_next.bits_left = st_reg.frame_bits - 4'h1;
					st_next.shifter   = {1'b0, st_reg.shifter[8:1]};
					st_next.state     = AST_DATA;
				end
			end
			AST_DATA: begin
				if (bit_tick) begin
					if (st_reg.bits_left == 4'h0) begin
						st_next.line  = 1'b1;
						st_next.state = AST_STOP;
					end else begin
						st_next.line      = st_reg.shifter[0];
						st_next.shifter   = {1'b0, st_reg.shifter[8:1]};
						st_next.bits_left = st_reg.bits_left - 4'h1;
					end
				end
			end
			AST_STOP: begin
				if (bit_tick) begin
					// pending character goes straight to start, no idle gap
					if (tx_active && st_reg.hold_full) begin
						st_next.shifter    = {st_reg.hold_ninth, st_reg.hold_data};
						st_next.frame_bits = st_reg.tx_ctl[TXS_NINE_BIT] ? DATA_BITS_NINE
							: DATA_BITS_EIGHT;
						st_next.hold_full  = write_hold;
						st_next.line       = 1'b0;
						st_next.state      = AST_START;
					end else begin
						st_next.line  = 1'b1;
						st_next.state = AST_IDLE;
					end
				end
			end
			default: begin
				st_next.state = AST_IDLE;
				st_next.line  = 1'b1;
			end
		endcase

		// dropping the enable abandons the frame and flushes the buffer
		if (!tx_active) begin
			st_next.state = AST_IDLE;
			st_next.line  = 1'b1;
			if (!st_reg.tx_ctl[TXS_TX_ENABLE]) begin
				st_next.hold_full = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg         <= '0;
			st_reg.line    <= 1'b1;
			st_reg.state   <= AST_IDLE;
			st_reg.divisor <= RESET_DIVISOR;
			st_reg.tx_ctl  <= RESET_BYTE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
	assign transmit_clock_pin_o  = st_reg.port_enable ? st_reg.line : gpio_out;
	assign transmit_clock_pin_oe = st_reg.port_enable ? 1'b1 : gpio_oe;
	assign transmit_irq = st_reg.flag_shown && (&st_reg.int_ctl);

endmodule : ast_transmitter

// ==== ast_checker.sv ====
// port assertions for the serial transmitter
`timescale 1ns/1ns
module ast_checker (
	input wire logic       clk,
	input wire logic       srst,
	input wire logic [2:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       gpio_out,
	input wire logic       gpio_oe,
	input wire logic       transmit_clock_pin_o,
	input wire logic       transmit_clock_pin_oe,
	input wire logic       transmit_irq
);
	logic [5:0] low_run_reg;
	wire        act_low = transmit_clock_pin_oe && !transmit_clock_pin_o;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// bit figures assume a four-clock bit period
	always_ff @(posedge clk) begin
		if (srst || !act_low)
			low_run_reg <= 6'h00;
		else if (low_run_reg != 6'h3F)
			low_run_reg <= low_run_reg + 6'h01;
	end
	AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	AST_UNMAPPED: assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_RESET_IRQ: assert property ($fell(srst) |-> !transmit_irq)
		else $error("irq after reset");
	AST_RESET_PIN: assert property ($fell(srst) |-> transmit_clock_pin_oe == gpio_oe)
		else $error("pin not released after reset");
	AST_RELEASE: assert property (!transmit_clock_pin_oe |-> transmit_clock_pin_o == gpio_out)
		else $error("released pin not general purpose");
	AST_START_LEN: assert property ($rose(act_low) |-> act_low [*4])
		else $error("space bit too short");
	AST_BIT_STABLE: assert property ($rose(act_low) |-> ##5 $stable(transmit_clock_pin_o) [*3])
		else $error("line moved inside a bit");
	AST_LOW_RUN: assert property (low_run_reg < 6'h29)
		else $error("line low too long");
endmodule : ast_checker
bind ast_transmitter ast_checker u_ast_checker (
	.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
	.transmit_clock_pin_o(transmit_clock_pin_o),
	.transmit_clock_pin_oe(transmit_clock_pin_oe), .transmit_irq(transmit_irq)
);

// ==== ast_line_rx.sv ====
// far-end receiver that decodes line frames into a queue
`timescale 1ns/1ns
module ast_line_rx #(
	parameter int BIT_CLKS = 4
) (
	input wire logic clk,
	input wire logic line,
	input wire logic nine
);
	logic [8:0] rx_q[$];
	int         ferr_cnt = 0;
	initial begin : decode
		logic [8:0] d;
		forever begin
			@(posedge clk iff !line);
			d = 9'h000;
			repeat (BIT_CLKS / 2) @(posedge clk);
			for (int i = 0; i < (nine ? 9 : 8); i++) begin
				repeat (BIT_CLKS) @(posedge clk);
				d[i] = line;
			end
			repeat (BIT_CLKS) @(posedge clk);
			if (line !== 1'b1)
				ferr_cnt++;
			rx_q.push_back(d);
		end
	end
endmodule : ast_line_rx

// ==== test_ast_transmitter.sv ====
// self-checking testbench for the serial transmitter
`timescale 1ns/1ns
module test_ast_transmitter;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic       gpio_out = 1'b1;
	logic       gpio_oe = 1'b1;
	logic       pin_o;
	logic       pin_oe;
	logic       irq;
	logic       nine = 1'b0;
	int         n_errors = 0;
	int         n_checks = 0;
	ast_transmitter u_ast_transmitter (.clk(clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .transmit_clock_pin_o(pin_o),
		.transmit_clock_pin_oe(pin_oe), .transmit_irq(irq));
	// released line is pulled to mark
	ast_line_rx u_ast_line_rx (.clk(clk), .line(pin_oe ? pin_o : 1'b1), .nine(nine));
	initial forever #4 clk = ~clk;
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk({1'b0, reg_rdata}, {1'b0, e});
	endtask : rd
	task automatic wait_rx(input int n);
		repeat (400) if (u_ast_line_rx.rx_q.size() < n) @(posedge clk);
		if (u_ast_line_rx.rx_q.size() < n) begin
			n_errors++;
			$display("mismatch at %0t: frame not received in time", $time);
		end
	endtask : wait_rx
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd(3'h0, 8'h02);
		rd(3'h6, 8'h00);
		rd(3'h7, 8'h00);
		@(posedge clk);
		gpio_oe  <= 1'b0;
		gpio_out <= 1'b0;
		@(posedge clk);
		#1 chk(pin_o, 1'b0);
		chk(pin_oe, 1'b0);
		@(posedge clk);
		gpio_oe  <= 1'b1;
		gpio_out <= 1'b1;
		$display("test reset and release done");
		// divisor 3, wide and high speed: four clocks a bit
		wr(3'h3, 8'h03);
		wr(3'h4, 8'h00);
		wr(3'h2, 8'h08);
		wr(3'h1, 8'h80);
		@(posedge clk);
		#1 chk(pin_oe, 1'b1);
		chk(pin_o, 1'b1);
		wr(3'h0, 8'h24);
		rd(3'h6, 8'h10);
		wr(3'h6, 8'h07);
		@(posedge clk);
		#1 chk(irq, 1'b1);
		wr(3'h6, 8'h03);
		@(posedge clk);
		#1 chk(irq, 1'b0);
		rd(3'h6, 8'h13);
		$display("test setup done");
		wr(3'h5, 8'hA5);
		wr(3'h5, 8'h3C);
		rd(3'h6, 8'h13);
		rd(3'h6, 8'h03);
		rd(3'h0, 8'h24);
		wait_rx(2);
		repeat (8) @(posedge clk);
		rd(3'h0, 8'h26);
		rd(3'h6, 8'h13);
		chk(u_ast_line_rx.rx_q.pop_front(), 9'h0A5);
		chk(u_ast_line_rx.rx_q.pop_front(), 9'h03C);
		$display("test back to back done");
		@(posedge clk);
		nine <= 1'b1;
		wr(3'h0, 8'h65);
		wr(3'h5, 8'h00);
		wait_rx(1);
		chk(u_ast_line_rx.rx_q.pop_front(), 9'h100);
		chk(9'(u_ast_line_rx.ferr_cnt), 9'h000);
		$display("test nine bit done");
		repeat (4) @(posedge clk);
		nine <= 1'b0;
		wr(3'h0, 8'h34);
		wr(3'h5, 8'h5A);
		repeat (8) @(posedge clk);
		rd(3'h0, 8'h36);
		chk(pin_o, 1'b1);
		rd(3'h6, 8'h03);
		wr(3'h0, 8'h24);
		wait_rx(1);
		chk(u_ast_line_rx.rx_q.pop_front(), 9'h05A);
		$display("test sync mode hold done");
		close_out();
	end
	initial begin
		#20000;
		n_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		close_out();
	end
endmodule : test_ast_transmitter
